// ### hdl/dsc_map.svh
// register offsets, field positions, reset values and counts of the sync control block
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH
`define DSC_ADR_CTRL 6'h00
`define DSC_ADR_DIV 6'h01
`define DSC_ADR_DLY 6'h02
`define DSC_ADR_STATUS 6'h03
`define DSC_ADR_INC 6'h04
`define DSC_CTRL_LPOL 0
`define DSC_CTRL_FPOL 1
`define DSC_CTRL_DSRC 2
`define DSC_CTRL_CSSEL 3
`define DSC_CTRL_CSEN 4
`define DSC_CTRL_FREEZE 5
`define DSC_CTRL_FMT_LO 6
`define DSC_CTRL_FMT_HI 7
`define DSC_ST_LOCK 0
`define DSC_ST_ADDR 1
`define DSC_ST_CLAMP 2
`define DSC_ST_FRAME 3
`define DSC_CTRL_RST 8'h00
`define DSC_DIV_RST 12'h320
`define DSC_DLY_RST 4'h0
`define DSC_INC_RST 16'h4000
`define DSC_LOCK_EDGES 4'h8
`define DSC_STRAP_WAIT 2'h3
`endif

// ### hdl/dsc_pkg.sv
// types shared by the sync control block
package dsc_pkg;
   typedef enum logic [1:0] {
      FMT_BUS_A,
      FMT_BUS_AB,
      FMT_BUS_B,
      FMT_NONE
   } dsc_fmt_type;
endpackage

// ### hdl/dsc_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module dsc_sync2 #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [W-1:0] async,
   output logic [W-1:0] synced
);
   logic [W-1:0] meta_r;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta_r <= '0;
         synced <= '0;
      end else begin
         meta_r <= async;
         synced <= meta_r;
      end
   end
endmodule // dsc_sync2
`default_nettype wire

// ### hdl/dsc_sync_control_io.sv
// sync input/output, digital pll and data bus gating of the digitizer
`timescale 1ns/1ps
`default_nettype none
`include "dsc_map.svh"
module dsc_sync_control_io #(
   parameter int DATA_W = 24,
   parameter int DIV_W = 12,
   parameter int ACC_W = 16,
   parameter int DLY_DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic slaveAddrLsbStrap,
   input wire logic externalClampPulse,
   input wire logic lineSyncIn,
   input wire logic frameSyncIn,
   input wire logic firstVideoChannelSync,
   input wire logic compositeSyncIn,
   input wire logic outputEnable_n,
   input wire logic [DATA_W-1:0] busAData,
   input wire logic [DATA_W-1:0] busBData,
   output logic slaveAddrLsb,
   output logic clampActive,
   output logic frameSyncActive,
   output logic displayLineSyncOut,
   output logic compositeSyncOut,
   output logic lockDetect,
   output logic [DATA_W-1:0] busAOut,
   output logic busAOe,
   output logic [DATA_W-1:0] busBOut,
   output logic busBOe,
   output dsc_pkg::dsc_fmt_type formatterMode
);
   import dsc_pkg::*;
   localparam int TAP_W = $clog2(DLY_DEPTH);

   typedef struct packed {
      logic [7:0] ctrl;
      logic [DIV_W-1:0] divTotal;
      logic [TAP_W-1:0] dlyTap;
      logic ack;
      logic [31:0] rdat;
      logic [1:0] strapWait;
      logic strapTaken;
      logic addrLsb;
      logic lineD;
      logic [DLY_DEPTH-1:0] dlyLine;
      logic [ACC_W-1:0] digital_tuned_oscillator;
      logic [ACC_W-1:0] inc;
      logic [DIV_W-1:0] divCnt;
      logic divPulse;
      logic [3:0] lockCnt;
      logic locked;
      logic dispSync;
      logic csOut;
      logic clamp;
      logic frame;
      logic [DATA_W-1:0] aOut;
      logic aOe;
      logic [DATA_W-1:0] bOut;
      logic bOe;
      dsc_fmt_type fmt;
   } dsc_state_type;

   dsc_state_type s_r, s_nxt;
   logic [6:0] pinS;
   logic strapS, clampS, lineS, frameS, chanS, csInS, oeNS;

   dsc_sync2 #(.W(7)) u_pins (
      .mclk(mclk),
      .rst(rst),
      .async({slaveAddrLsbStrap, externalClampPulse, lineSyncIn,
              frameSyncIn, firstVideoChannelSync, compositeSyncIn,
              outputEnable_n}),
      .synced(pinS)
   );
   assign {strapS, clampS, lineS, frameS, chanS, csInS, oeNS} = pinS;

   logic lineN, frameN, refEdge, usesA, usesB, busReq;
   logic [ACC_W:0] accSum;
   assign lineN = lineS ^ s_r.ctrl[`DSC_CTRL_LPOL];
   assign frameN = frameS ^ s_r.ctrl[`DSC_CTRL_FPOL];
   assign refEdge = lineN & ~s_r.lineD;
   assign usesA = (s_r.fmt == FMT_BUS_A) || (s_r.fmt == FMT_BUS_AB);
   assign usesB = (s_r.fmt == FMT_BUS_B) || (s_r.fmt == FMT_BUS_AB);
   assign busReq = wb_cyc_i & wb_stb_i & ~s_r.ack;
   assign accSum = {1'b0, s_r.digital_tuned_oscillator} + {1'b0, s_r.inc};

   always_comb begin
      s_nxt = s_r;
      // classic wishbone: one wait state, unmapped reads give zero
      s_nxt.ack = busReq;
      if (busReq) begin
         s_nxt.rdat = 32'h0;
         unique case (wb_adr_i[7:2])
            `DSC_ADR_CTRL: s_nxt.rdat = 32'(s_r.ctrl);
            `DSC_ADR_DIV: s_nxt.rdat = 32'(s_r.divTotal);
            `DSC_ADR_DLY: s_nxt.rdat = 32'(s_r.dlyTap);
            `DSC_ADR_STATUS: begin
               s_nxt.rdat[`DSC_ST_LOCK] = s_r.locked;
               s_nxt.rdat[`DSC_ST_ADDR] = s_r.addrLsb;
               s_nxt.rdat[`DSC_ST_CLAMP] = s_r.clamp;
               s_nxt.rdat[`DSC_ST_FRAME] = s_r.frame;
            end
            `DSC_ADR_INC: s_nxt.rdat = 32'(s_r.inc);
            default: s_nxt.rdat = 32'h0;
         endcase
         if (wb_we_i) begin
            if (wb_adr_i[7:2] == `DSC_ADR_CTRL && wb_sel_i[0]) begin
               s_nxt.ctrl = wb_dat_i[7:0];
            end
            if (wb_adr_i[7:2] == `DSC_ADR_DIV && wb_sel_i[0]) begin
               s_nxt.divTotal = wb_dat_i[DIV_W-1:0];
            end
            if (wb_adr_i[7:2] == `DSC_ADR_DLY && wb_sel_i[0]) begin
               s_nxt.dlyTap = wb_dat_i[TAP_W-1:0];
            end
         end
      end
      // strap is caught once, after the synchroniser has filled
      if (!s_r.strapTaken) begin
         if (s_r.strapWait == `DSC_STRAP_WAIT) begin
            s_nxt.strapTaken = 1'b1;
            s_nxt.addrLsb = strapS;
         end else begin
            s_nxt.strapWait = s_r.strapWait + 2'h1;
         end
      end
      s_nxt.clamp = clampS;
      s_nxt.frame = frameN;
      s_nxt.lineD = lineN;
      s_nxt.dlyLine = {s_r.dlyLine[DLY_DEPTH-2:0], lineN};
      // dto and feedback divider
      s_nxt.digital_tuned_oscillator = accSum[ACC_W-1:0];
      s_nxt.divPulse = 1'b0;
      if (accSum[ACC_W]) begin
         if (s_r.divCnt >= DIV_W'(s_r.divTotal - 1'b1)) begin
            s_nxt.divCnt = '0;
            s_nxt.divPulse = 1'b1;
         end else begin
            s_nxt.divCnt = s_r.divCnt + 1'b1;
         end
      end
      // detector acts on the reference edge; divider phase is the error
      if (refEdge) begin
         if (s_r.divCnt == '0 ||
             s_r.divCnt == DIV_W'(s_r.divTotal - 1'b1)) begin
            if (s_r.lockCnt != `DSC_LOCK_EDGES) begin
               s_nxt.lockCnt = s_r.lockCnt + 4'h1;
            end
         end else begin
            s_nxt.lockCnt = 4'h0;
         end
         if (!s_r.ctrl[`DSC_CTRL_FREEZE] && s_r.divCnt != '0) begin
            if (s_r.divCnt < (s_r.divTotal >> 1)) begin
               s_nxt.inc = s_r.inc - 1'b1;
            end else begin
               s_nxt.inc = s_r.inc + 1'b1;
            end
         end
      end
      s_nxt.locked = (s_r.lockCnt == `DSC_LOCK_EDGES);
      s_nxt.dispSync = s_r.ctrl[`DSC_CTRL_DSRC] ? s_r.divPulse
                                              : s_r.dlyLine[s_r.dlyTap];
      s_nxt.csOut = s_r.ctrl[`DSC_CTRL_CSEN] &
                    (s_r.ctrl[`DSC_CTRL_CSSEL] ? csInS : chanS);
      s_nxt.fmt = dsc_fmt_type'(s_r.ctrl[`DSC_CTRL_FMT_HI:`DSC_CTRL_FMT_LO]);
      // data follows its bus even when parked, only the enables gate
      s_nxt.aOut = busAData;
      s_nxt.bOut = busBData;
      // synchroniser resets to 0, which reads as enabled: wait till filled
      s_nxt.aOe = ~oeNS & usesA & s_r.strapWait[1];
      s_nxt.bOe = ~oeNS & usesB & s_r.strapWait[1];
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
         s_r.ctrl <= `DSC_CTRL_RST;
         s_r.divTotal <= `DSC_DIV_RST;
         s_r.dlyTap <= `DSC_DLY_RST;
         s_r.inc <= `DSC_INC_RST;
         s_r.fmt <= FMT_BUS_A;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign wb_ack_o = s_r.ack;
   assign wb_dat_o = s_r.rdat;
   assign slaveAddrLsb = s_r.addrLsb;
   assign clampActive = s_r.clamp;
   assign frameSyncActive = s_r.frame;
   assign displayLineSyncOut = s_r.dispSync;
   assign compositeSyncOut = s_r.csOut;
   assign lockDetect = s_r.locked;
   assign busAOut = s_r.aOut;
   assign busAOe = s_r.aOe;
   assign busBOut = s_r.bOut;
   assign busBOe = s_r.bOe;
   assign formatterMode = s_r.fmt;

   sequence seq_bus_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence seq_ack_once;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   a_wb_ack_once: assert property (@(posedge mclk) disable iff (rst)
      seq_bus_req |=> seq_ack_once)
      else $error("bus ack not a single pulse after request");
   a_strap_capture: assert property (@(posedge mclk) disable iff (rst)
      $rose(s_r.strapTaken) |-> slaveAddrLsb == $past(strapS))
      else $error("address lsb differs from strap");
   a_clamp_follow: assert property (@(posedge mclk) disable iff (rst)
      ##1 clampActive == $past(clampS))
      else $error("clamp output does not follow clamp pin");
   a_frame_polarity: assert property (@(posedge mclk) disable iff (rst)
      ##1 frameSyncActive ==
         $past(frameS ^ s_r.ctrl[`DSC_CTRL_FPOL]))
      else $error("frame sync polarity wrong");
   a_ref_edge_norm: assert property (@(posedge mclk) disable iff (rst)
      refEdge |-> (lineS != s_r.ctrl[`DSC_CTRL_LPOL]) &&
         $past(lineS == s_r.ctrl[`DSC_CTRL_LPOL]))
      else $error("reference edge taken on inactive level");
   a_disp_source: assert property (@(posedge mclk) disable iff (rst)
      s_r.ctrl[`DSC_CTRL_DSRC] && s_r.divPulse |=> displayLineSyncOut)
      else $error("divider pulse missing on display sync");
   a_cs_source: assert property (@(posedge mclk) disable iff (rst)
      !s_r.ctrl[`DSC_CTRL_CSEN] |=> !compositeSyncOut)
      else $error("composite sync driven while disabled");
   a_lock_detect: assert property (@(posedge mclk) disable iff (rst)
      s_r.lockCnt != `DSC_LOCK_EDGES |=> !lockDetect)
      else $error("lock shown before enough aligned edges");
   a_freeze_hold: assert property (@(posedge mclk) disable iff (rst)
      s_r.ctrl[`DSC_CTRL_FREEZE] |=> $stable(s_r.inc))
      else $error("increment changed while frozen");
   a_bus_gate: assert property (@(posedge mclk) disable iff (rst)
      busAOe || busBOe |-> $past(!oeNS))
      else $error("data bus driven while output enable high");
endmodule // dsc_sync_control_io
`default_nettype wire

// ### sim/dsc_sync_source.sv
// line, frame and clamp source on the far side of the digitizer
`timescale 1ns/1ps
`default_nettype none
module dsc_sync_source #(
   parameter int PERIOD = 32
) (
   input wire logic mclk,
   input wire logic run,
   input wire logic lvl,
   input wire logic lowPol,
   output logic lineSync,
   output logic frameSync,
   output logic clampPulse
);
   int cnt = 0;
   always @(posedge mclk) begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
   end
   // stopped source holds static levels so the bench can set pins
   assign lineSync = run ? ((cnt < 4) ^ lowPol) : lvl;
   assign frameSync = run ? ((cnt < 2) ^ lowPol) : lvl;
   // while running, clamp only on the back porch, never overlapping sync
   assign clampPulse = run ? (cnt >= 5 && cnt < 8) : lvl;
endmodule // dsc_sync_source
`default_nettype wire

// ### sim/dsc_sync_control_io_test.sv
// self-checking bench for the sync control block
`timescale 1ns/1ps
`default_nettype none
module dsc_sync_control_io_test;
   import dsc_pkg::*;
   logic mclk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd, inc0;
   logic slaveAddrLsbStrap, lvl, run, lowPol, lineSyncIn, frameSyncIn;
   logic externalClampPulse, firstVideoChannelSync, compositeSyncIn;
   logic outputEnable_n, slaveAddrLsb, clampActive, frameSyncActive;
   logic displayLineSyncOut, compositeSyncOut, lockDetect, busAOe, busBOe;
   logic [23:0] busAData, busBData, busAOut, busBOut;
   dsc_fmt_type formatterMode;
   int failures = 0, checks_done = 0, n;
   typedef struct {logic [7:0] c; logic [3:0] i; logic [5:0] e;} dsc_row_type;
   // ctrl, {level, channel sync, cs input, enable_n}, expected pins
   dsc_row_type rows [6] = '{'{8'h00, 4'hc, 6'h3a}, '{8'h11, 4'hc, 6'h36},
      '{8'h5a, 4'h2, 6'h17}, '{8'h98, 4'hc, 6'h39},
      '{8'h43, 4'h9, 6'h20}, '{8'hc0, 4'h0, 6'h00}};
   dsc_sync_control_io u_dut (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .slaveAddrLsbStrap(slaveAddrLsbStrap),
      .externalClampPulse(externalClampPulse), .lineSyncIn(lineSyncIn),
      .frameSyncIn(frameSyncIn), .compositeSyncIn(compositeSyncIn),
      .firstVideoChannelSync(firstVideoChannelSync),
      .outputEnable_n(outputEnable_n), .busAData(busAData),
      .busBData(busBData), .slaveAddrLsb(slaveAddrLsb),
      .clampActive(clampActive), .frameSyncActive(frameSyncActive),
      .displayLineSyncOut(displayLineSyncOut), .lockDetect(lockDetect),
      .compositeSyncOut(compositeSyncOut), .busAOut(busAOut),
      .busAOe(busAOe), .busBOut(busBOut), .busBOe(busBOe),
      .formatterMode(formatterMode));
   dsc_sync_source u_src (.mclk(mclk), .run(run), .lvl(lvl),
      .lowPol(lowPol), .lineSync(lineSyncIn), .frameSync(frameSyncIn),
      .clampPulse(externalClampPulse));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // waits for ack without assuming its latency
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (wb_ack_o !== 1'b1) begin
         failures++;
         $display("[FAIL] %0t no bus ack", $time);
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      finish_test;
   end
   initial begin
      {rst, wb_cyc_i, wb_stb_i, wb_we_i, run, lowPol, lvl} = 7'h40;
      {slaveAddrLsbStrap, firstVideoChannelSync, compositeSyncIn} = 3'h0;
      {wb_adr_i, wb_dat_i, outputEnable_n} = '0;
      busAData = 24'h5a3c96;
      busBData = 24'ha5c369;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      chk(lockDetect, 1'b0);
      wb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h320);
      wb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h4000);
      wb(1'b1, 8'h14, 32'h55);
      wb(1'b0, 8'h14, 32'h0);
      chk(rd, 32'h0);
      $display("test registers done");
      foreach (rows[k]) begin
         wb(1'b1, 8'h00, {24'h0, rows[k].c});
         {lvl, firstVideoChannelSync, compositeSyncIn} <= rows[k].i[3:1];
         outputEnable_n <= rows[k].i[0];
         repeat (8) @(posedge mclk);
         chk({clampActive, frameSyncActive, displayLineSyncOut,
            compositeSyncOut, busAOe, busBOe}, rows[k].e);
         chk(formatterMode, rows[k].c[7:6]);
         chk(busBOut, busBData);
         chk(busAOut, busAData);
      end
      $display("test pin table done");
      for (int s = 0; s < 2; s++) begin
         @(posedge mclk);
         slaveAddrLsbStrap <= s[0];
         rst <= 1'b1;
         @(posedge mclk);
         chk({busAOe, lockDetect}, 2'b00);
         rst <= 1'b0;
         repeat (6) @(posedge mclk);
         chk(slaveAddrLsb, s[0]);
         wb(1'b0, 8'h0c, 32'h0);
         chk(rd[1], s[0]);
      end
      $display("test strap done");
      {lvl, outputEnable_n} <= 2'b00;
      wb(1'b1, 8'h04, 32'h8);
      wb(1'b1, 8'h00, 32'h0);
      run <= 1'b1;
      n = 0;
      // bang-bang loop may need over a hundred line periods to pull in
      while (lockDetect !== 1'b1 && n < 8000) begin
         @(posedge mclk);
         n++;
      end
      chk(lockDetect, 1'b1);
      wb(1'b0, 8'h0c, 32'h0);
      chk(rd[0], 1'b1);
      $display("test lock done");
      wb(1'b1, 8'h00, 32'h20);
      wb(1'b0, 8'h10, 32'h0);
      inc0 = rd;
      repeat (200) @(posedge mclk);
      wb(1'b0, 8'h10, 32'h0);
      chk(rd, inc0);
      $display("test freeze done");
      run <= 1'b0;
      wb(1'b1, 8'h00, 32'h04);
      n = 0;
      repeat (100) begin
         @(posedge mclk);
         if (displayLineSyncOut === 1'b1) n++;
      end
      chk(n == 3 || n == 4, 1'b1);
      $display("test divider pulse done");
      finish_test;
   end
endmodule // dsc_sync_control_io_test
`default_nettype wire
